// ---- verilog/fswg_pkg.sv ----
// Function
// - flash splits into boot, app code, app data in 256-byte blocks via two fuses
// - boot region spans address zero up to 256 times boot end fuse
// - boot end fuse zero makes whole flash boot region
// - app end zero, boot end nonzero: app code to flash end, no data
// - app end nonzero but not above boot end: no app code, data to end
// - app end above boot end: code to 256*app end, data takes rest
// - boundary above flash size: fuse ignored, default used
// - boot code may write app code and app data regions
// - app code may write app data region
// - code in app data may not write flash or eeprom
// - cpu never writes the boot region
// - boot read lock blocks data reads and execution from boot region
// - boot lock set only from boot code, effective after leaving boot
// - app code write protect blocks updates of app code region; debug port writes bypass it while the device is unlocked
// - flash writes and erases act on whole pages
// - eeprom page operation touches only marked bytes
// - writing an eeprom or user row byte into page buffer marks it for update
// - user row survives chip erase
// - user row writable as eeprom, and by debug port while locked
// - vectors at app code start after reset, relocate moves them to boot start
package fswg_pkg;
   localparam int FLASH_AW      = 14;
   localparam int FUSE_W        = 8;
   localparam int BLOCK_SHIFT   = 8;
   localparam int FLASH_PAGE_W  = 6;
   localparam int EE_AW         = 8;
   localparam int EE_PAGE_W     = 5;
   localparam int EE_PAGE_BYTES = 32;
   localparam logic [FLASH_AW:0]  FLASH_SIZE      = 15'h4000;
   localparam logic [FUSE_W-1:0]  BOOT_END_DFLT   = 8'h00;
   localparam logic [FUSE_W-1:0]  APP_END_DFLT    = 8'h00;
   localparam logic               BOOT_LOCK_RST   = 1'b0;
   localparam logic               APC_WP_RST      = 1'b0;
   localparam logic               VEC_RELOC_RST   = 1'b0;

   typedef enum logic [1:0] {
      FSWG_REG_BOOT = 2'b00,
      FSWG_REG_CODE = 2'b01,
      FSWG_REG_DATA = 2'b10
   } fswg_region_e;

   typedef enum logic [1:0] {
      FSWG_TGT_FLASH = 2'b00,
      FSWG_TGT_EEPROM = 2'b01,
      FSWG_TGT_USER = 2'b10
   } fswg_target_e;

   typedef struct packed {
      logic                valid;
      logic                from_debug;
      fswg_target_e        target;
      logic [FLASH_AW-1:0] addr;
      logic [7:0]          data;
   } fswg_wreq_s;

   typedef struct packed {
      logic                valid;
      logic                chip_erase;
      fswg_target_e        target;
      logic [FLASH_AW-1:0] addr;
   } fswg_cmd_s;
endpackage : fswg_pkg

// ---- verilog/fswg_guard.sv ----
`timescale 1ns/1ps
`default_nettype none
module fswg_guard import fswg_pkg::*; (
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic [FUSE_W-1:0]    boot_end_fuse,
   input  wire logic [FUSE_W-1:0]    app_code_end_fuse,
   input  wire logic [FLASH_AW-1:0]  cpu_pc,
   input  wire logic                 rd_valid,
   input  wire logic                 rd_fetch,
   input  wire logic [FLASH_AW-1:0]  rd_addr,
   input  wire fswg_wreq_s           wreq,
   input  wire fswg_cmd_s            cmd,
   input  wire logic                 boot_lock_set,
   input  wire logic                 app_wp_set,
   input  wire logic                 vector_relocate_select,
   input  wire logic                 device_locked,
   output logic                      rd_allow,
   output logic                      wreq_ready,
   output fswg_region_e              exec_region,
   output logic [FLASH_AW-1:0]       boot_end_addr_q,
   output logic [FLASH_AW:0]         code_end_addr_q,
   output logic [FLASH_AW-1:0]       vector_base_q,
   output logic                      boot_read_lock_q,
   output logic                      app_code_write_protect_q,
   output logic                      pb_wr_q,
   output logic [EE_PAGE_W-1:0]      pb_idx_q,
   output logic [7:0]                pb_data_q,
   output logic                      nvm_op_q,
   output logic                      nvm_chip_erase_q,
   output fswg_target_e              nvm_target_q,
   output logic [FLASH_AW-1:0]       nvm_page_addr_q,
   output logic [EE_PAGE_BYTES-1:0]  nvm_byte_mask_q,
   output logic                      nvm_keep_user_q,
   output logic                      wr_denied_q
);
   // ==================================================
   // region decode
   logic [FLASH_AW+8:0]      be_raw;
   logic [FLASH_AW+8:0]      ae_raw;
   logic [FUSE_W-1:0]        be_f;
   logic [FUSE_W-1:0]        ae_f;
   logic [FLASH_AW:0]        be_b;
   logic [FLASH_AW:0]        ae_b;
   logic                     boot_lock_armed_q;
   logic [EE_PAGE_BYTES-1:0] mark_q;
   logic                     in_boot_exec;
   logic                     wreq_ok;
   logic                     wreq_marks;
   logic                     cmd_ok;
   logic [EE_PAGE_W-1:0]     wreq_idx;

   // fuse times block size, wide enough to see overflow
   always_comb begin
      be_raw = 23'({boot_end_fuse, 8'h00});
      ae_raw = 23'({app_code_end_fuse, 8'h00});
   end

   // out-of-range fuse falls back to its default
   always_comb begin
      if (be_raw > 23'(FLASH_SIZE)) begin
         be_f = BOOT_END_DFLT;
      end else begin
         be_f = boot_end_fuse;
      end
      if (ae_raw > 23'(FLASH_SIZE)) begin
         ae_f = APP_END_DFLT;
      end else begin
         ae_f = app_code_end_fuse;
      end
   end

   // boundaries as byte addresses
   always_comb begin
      be_b = 15'({be_f, 8'h00});
      ae_b = 15'({ae_f, 8'h00});
      if (be_f == 8'h00) begin
         be_b = FLASH_SIZE;
         ae_b = FLASH_SIZE;
      end else if (ae_f == 8'h00) begin
         ae_b = FLASH_SIZE;
      end else if (ae_f <= be_f) begin
         ae_b = be_b;
      end
   end

   function automatic fswg_region_e region_of(input logic [FLASH_AW-1:0] a);
      fswg_region_e r;
      if ({1'b0, a} < be_b) begin
         r = FSWG_REG_BOOT;
      end else if ({1'b0, a} < ae_b) begin
         r = FSWG_REG_CODE;
      end else begin
         r = FSWG_REG_DATA;
      end
      return r;
   endfunction : region_of

   // a process, so fuse changes alone also re-evaluate the region
   always_comb begin
      exec_region = region_of(cpu_pc);
   end

   assign in_boot_exec = (exec_region == FSWG_REG_BOOT);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         boot_end_addr_q <= '0;
      end else if (be_b == FLASH_SIZE) begin
         boot_end_addr_q <= '0;
      end else begin
         boot_end_addr_q <= be_b[FLASH_AW-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         code_end_addr_q <= '0;
      end else begin
         code_end_addr_q <= ae_b;
      end
   end

   // vectors follow the code region start unless relocated
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         vector_base_q <= '0;
      end else if (vector_relocate_select) begin
         vector_base_q <= '0;
      end else begin
         vector_base_q <= boot_end_addr_q;
      end
   end

   // ==================================================
   // lock bits
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         boot_lock_armed_q <= BOOT_LOCK_RST;
      end else if (boot_lock_set && in_boot_exec) begin
         boot_lock_armed_q <= 1'b1;
      end
   end

   // lock bites only once execution has left boot
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         boot_read_lock_q <= BOOT_LOCK_RST;
      end else if (boot_lock_armed_q && !in_boot_exec) begin
         boot_read_lock_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         app_code_write_protect_q <= APC_WP_RST;
      end else if (app_wp_set) begin
         app_code_write_protect_q <= 1'b1;
      end
   end

   // ==================================================
   // read / fetch gate
   always_comb begin
      rd_allow = 1'b1;
      if (rd_valid && boot_read_lock_q && region_of(rd_addr) == FSWG_REG_BOOT) begin
         rd_allow = 1'b0;
      end
      if (rd_valid && rd_fetch && boot_read_lock_q && in_boot_exec) begin
         rd_allow = 1'b0;
      end
   end

   // ==================================================
   // write permission
   function automatic logic write_ok(input fswg_target_e t,
                                     input logic         dbg,
                                     input logic [FLASH_AW-1:0] a);
      fswg_region_e dst;
      logic         ok;
      dst = region_of(a);
      if (t == FSWG_TGT_USER && dbg) begin
         ok = 1'b1;
      end else if (dbg) begin
         ok = !device_locked;
      end else if (exec_region == FSWG_REG_DATA) begin
         ok = 1'b0;
      end else if (t != FSWG_TGT_FLASH) begin
         ok = 1'b1;
      end else if (dst == FSWG_REG_BOOT) begin
         ok = 1'b0;
      end else if (dst == FSWG_REG_CODE) begin
         ok = (exec_region == FSWG_REG_BOOT) && !app_code_write_protect_q;
      end else begin
         ok = 1'b1;
      end
      return ok;
   endfunction : write_ok

   always_comb begin
      wreq_ok    = wreq.valid && write_ok(wreq.target, wreq.from_debug, wreq.addr);
      cmd_ok     = cmd.valid && (cmd.chip_erase || write_ok(cmd.target, 1'b0, cmd.addr));
      wreq_idx   = wreq.addr[EE_PAGE_W-1:0];
      wreq_marks = wreq_ok && (wreq.target != FSWG_TGT_FLASH);
   end

   // refused writes are dropped, the port never waits
   assign wreq_ready = 1'b1;

   // ==================================================
   // page buffer path
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pb_wr_q <= 1'b0;
      end else begin
         pb_wr_q <= wreq_ok;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_denied_q <= 1'b0;
      end else begin
         wr_denied_q <= wreq.valid && !wreq_ok;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pb_idx_q <= '0;
      end else begin
         pb_idx_q <= wreq_idx;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pb_data_q <= '0;
      end else begin
         pb_data_q <= wreq.data;
      end
   end

   // ==================================================
   // eeprom byte marks
   // a byte stored in the issue cycle keeps its mark for the next page
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mark_q <= '0;
      end else if (nvm_op_q) begin
         mark_q <= '0;
         if (wreq_marks) begin
            mark_q[wreq_idx] <= 1'b1;
         end
      end else if (wreq_marks) begin
         mark_q[wreq_idx] <= 1'b1;
      end
   end

   // ==================================================
   // nvm operation issue
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_op_q <= 1'b0;
      end else begin
         nvm_op_q <= cmd_ok;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_chip_erase_q <= 1'b0;
      end else begin
         nvm_chip_erase_q <= cmd.valid && cmd.chip_erase;
      end
   end

   // chip erase leaves the user row alone
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_keep_user_q <= 1'b0;
      end else begin
         nvm_keep_user_q <= cmd.valid && cmd.chip_erase;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_target_q <= FSWG_TGT_FLASH;
      end else begin
         nvm_target_q <= cmd.target;
      end
   end

   // flash pages are 64 bytes, eeprom pages 32
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_page_addr_q <= '0;
      end else if (cmd.target == FSWG_TGT_FLASH) begin
         nvm_page_addr_q <= {cmd.addr[FLASH_AW-1:FLASH_PAGE_W], {FLASH_PAGE_W{1'b0}}};
      end else begin
         nvm_page_addr_q <= {cmd.addr[FLASH_AW-1:EE_PAGE_W], {EE_PAGE_W{1'b0}}};
      end
   end

   // flash always takes the whole page, eeprom only marked bytes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_byte_mask_q <= '0;
      end else if (cmd.target == FSWG_TGT_FLASH) begin
         nvm_byte_mask_q <= '1;
      end else begin
         nvm_byte_mask_q <= mark_q;
      end
   end
endmodule : fswg_guard
`default_nettype wire

// ---- sim/fswg_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fswg_props import fswg_pkg::*; (
   input wire logic                core_clk,
   input wire logic                nrst,
   input wire fswg_wreq_s          wreq,
   input wire logic                wreq_ready,
   input wire logic                pb_wr_q,
   input wire logic                wr_denied_q,
   input wire logic [FLASH_AW-1:0] boot_end_addr_q,
   input wire fswg_region_e        exec_region,
   input wire logic                boot_read_lock_q,
   input wire logic                boot_lock_set,
   input wire logic                rd_valid,
   input wire logic [FLASH_AW-1:0] rd_addr,
   input wire logic                rd_allow,
   input wire logic                vector_relocate_select,
   input wire logic [FLASH_AW-1:0] vector_base_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ==========================================
   // write, read and vector checks
   sequence s_cpu_wr; wreq.valid && !wreq.from_debug; endsequence
   sequence s_vec_still; (!vector_relocate_select && $stable(boot_end_addr_q))[*3]; endsequence
   property p_ready; wreq_ready; endproperty
   a_ready: assert property (p_ready) else $error("write port stalled");
   property p_answer; wreq.valid |=> pb_wr_q != wr_denied_q; endproperty
   a_answer: assert property (p_answer) else $error("write not answered once");
   property p_boot_wr;
      s_cpu_wr ##0 (wreq.target == FSWG_TGT_FLASH && wreq.addr < boot_end_addr_q) |=> wr_denied_q && !pb_wr_q;
   endproperty
   a_boot_wr: assert property (p_boot_wr) else $error("cpu wrote boot region");
   property p_data_wr; s_cpu_wr ##0 (exec_region == FSWG_REG_DATA) |=> wr_denied_q; endproperty
   a_data_wr: assert property (p_data_wr) else $error("write from data region");
   property p_lock_rd;
      boot_read_lock_q && rd_valid && exec_region != FSWG_REG_BOOT && rd_addr < boot_end_addr_q |-> !rd_allow;
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("locked boot read allowed");
   property p_lock_set; $rose(boot_read_lock_q) |-> $past(exec_region) != FSWG_REG_BOOT; endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock took effect inside boot");
   property p_pb_cause; pb_wr_q |-> $past(wreq.valid); endproperty
   a_pb_cause: assert property (p_pb_cause) else $error("buffer store without request");
   property p_vec; s_vec_still |-> vector_base_q == boot_end_addr_q; endproperty
   a_vec: assert property (p_vec) else $error("vector base not at code start");
endmodule : fswg_props
bind fswg_guard fswg_props i_props (.*);
`default_nettype wire

// ---- sim/fswg_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module fswg_host import fswg_pkg::*; (
   input  wire logic       core_clk,
   output var  fswg_wreq_s wreq,
   output var  fswg_cmd_s  cmd
);
   // ==========================================
   // cpu and debug port requests, one-cycle pulses
   initial begin
      wreq = '0;
      cmd = '0;
   end
   task automatic store(input logic dbg, input fswg_target_e t, input logic [FLASH_AW-1:0] a);
      @(posedge core_clk);
      wreq <= '{1'b1, dbg, t, a, 8'h5a};
      @(posedge core_clk);
      wreq <= '{1'b0, ~dbg, t, ~a, 8'ha5};
   endtask : store
   task automatic command(input logic ce, input fswg_target_e t, input logic [FLASH_AW-1:0] a);
      @(posedge core_clk);
      cmd <= '{1'b1, ce, t, a};
      @(posedge core_clk);
      cmd <= '{1'b0, ~ce, t, ~a};
   endtask : command
endmodule : fswg_host
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench import fswg_pkg::*;;
   logic                core_clk = 1'b0;
   logic                nrst = 1'b0;
   logic [FUSE_W-1:0]   boot_end_fuse = 8'h04;
   logic [FUSE_W-1:0]   app_code_end_fuse = 8'h08;
   logic [FLASH_AW-1:0] cpu_pc = 14'h0100;
   logic [FLASH_AW-1:0] rd_addr = 14'h0010;
   logic                rd_valid = 1'b0;
   logic                rd_fetch = 1'b0;
   logic                boot_lock_set = 1'b0;
   logic                app_wp_set = 1'b0;
   logic                vector_relocate_select = 1'b0;
   logic                device_locked = 1'b0;
   fswg_wreq_s          wreq;
   fswg_cmd_s           cmd;
   fswg_region_e        exec_region;
   logic [FLASH_AW-1:0] boot_end_addr_q, vector_base_q, nvm_page_addr_q;
   logic [31:0]         nvm_byte_mask_q;
   logic [7:0]          pb_data_q;
   logic                rd_allow, wreq_ready, boot_read_lock_q, app_code_write_protect_q;
   logic                pb_wr_q, nvm_op_q, nvm_keep_user_q, wr_denied_q, nvm_chip_erase_q;
   logic [EE_PAGE_W-1:0] pb_idx_q;
   int                  error_cnt = 0;
   int                  n_compared = 0;
   // {boot fuse, app fuse, pc, region}
   logic [31:0]         rt [10] = '{32'h0000ff00, 32'h0400fffd, 32'h04021002, 32'h04041002, 32'h04080ffc,
                                    32'h04081ffd, 32'h04082002, 32'h41004000, 32'h04418001, 32'h4000fffc};
   // {pc, target, addr, allowed}
   logic [30:0]         wt [7] = '{31'h02000a01, 31'h02001201, 31'h02000020, 31'h0a001201,
                                   31'h0a000020, 31'h12001400, 31'h12008006};

   always #25 core_clk = ~core_clk;
   fswg_guard i_dut (.*, .code_end_addr_q(), .nvm_target_q());
   fswg_host i_host (.core_clk, .wreq, .cmd);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 chk(vector_base_q, 32'h0400);
      chk(wreq_ready, 1'b1);
      foreach (rt[i]) begin
         @(posedge core_clk);
         {boot_end_fuse, app_code_end_fuse, cpu_pc} <= rt[i][31:2];
         repeat (3) @(posedge core_clk);
         #1 chk(exec_region, rt[i][1:0]);
      end
      $display("region decode done");
      @(posedge core_clk);
      {boot_end_fuse, app_code_end_fuse} <= 16'h0408;
      foreach (wt[i]) begin
         @(posedge core_clk);
         cpu_pc <= wt[i][30:17];
         i_host.store(1'b0, fswg_target_e'(wt[i][16:15]), wt[i][14:1]);
         #1 chk(pb_wr_q, wt[i][0]);
         chk(wr_denied_q, !wt[i][0]);
      end
      $display("write protection done");
      @(posedge core_clk);
      cpu_pc <= 14'h0500;
      boot_lock_set <= 1'b1;
      @(posedge core_clk);
      cpu_pc <= 14'h0100;
      #1 chk(boot_read_lock_q, 1'b0);
      @(posedge core_clk);
      boot_lock_set <= 1'b0;
      rd_valid <= 1'b1;
      #1 chk(boot_read_lock_q, 1'b0);
      chk(rd_allow, 1'b1);
      @(posedge core_clk);
      cpu_pc <= 14'h0500;
      rd_fetch <= 1'b1;
      @(posedge core_clk);
      #1 chk(rd_allow, 1'b0);
      chk(boot_read_lock_q, 1'b1);
      $display("boot lock done");
      @(posedge core_clk);
      cpu_pc <= 14'h0100;
      app_wp_set <= 1'b1;
      @(posedge core_clk);
      app_wp_set <= 1'b0;
      i_host.store(1'b0, FSWG_TGT_FLASH, 14'h0500);
      #1 chk(wr_denied_q, 1'b1);
      chk(app_code_write_protect_q, 1'b1);
      i_host.store(1'b0, FSWG_TGT_EEPROM, 14'h0003);
      i_host.store(1'b0, FSWG_TGT_EEPROM, 14'h0005);
      i_host.command(1'b0, FSWG_TGT_EEPROM, 14'h0000);
      #1 chk(nvm_byte_mask_q, 32'h00000028);
      chk(nvm_op_q, 1'b1);
      i_host.command(1'b0, FSWG_TGT_FLASH, 14'h0923);
      #1 chk(nvm_page_addr_q, 14'h0900);
      chk(nvm_byte_mask_q, 32'hffffffff);
      i_host.command(1'b1, FSWG_TGT_EEPROM, 14'h0000);
      #1 chk(nvm_keep_user_q, 1'b1);
      chk(nvm_chip_erase_q, 1'b1);
      $display("page operations done");
      @(posedge core_clk);
      device_locked <= 1'b1;
      vector_relocate_select <= 1'b1;
      i_host.store(1'b1, FSWG_TGT_USER, 14'h0002);
      #1 chk(pb_wr_q, 1'b1);
      chk(pb_data_q, 8'h5a);
      chk(pb_idx_q, 5'h02);
      repeat (2) @(posedge core_clk);
      #1 chk(vector_base_q, 32'h0);
      $display("user row and vectors done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
